// ### lbs_pkg.sv
// constants for the serial bus timing extension: register map, fields, events
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package lbs_pkg;

  // ***********************************************************
  // widths
  // ***********************************************************
  localparam int LBS_AW = 8;
  localparam int LBS_DW = 32;
  localparam int LBS_TW = 16;
  localparam int LBS_EVW = 7;

  // ***********************************************************
  // register byte offsets
  // ***********************************************************
  localparam logic [LBS_AW-1:0] LBS_MAIN_CONTROL = 8'h00;
  localparam logic [LBS_AW-1:0] LBS_BUS_TIMER_CONTROL = 8'h04;
  localparam logic [LBS_AW-1:0] LBS_BUS_TIMER_VALUE = 8'h08;
  localparam logic [LBS_AW-1:0] LBS_EDGE_CAPTURE_A = 8'h0C;
  localparam logic [LBS_AW-1:0] LBS_EDGE_CAPTURE_B = 8'h10;
  localparam logic [LBS_AW-1:0] LBS_EVENT_STATUS = 8'h14;
  localparam logic [LBS_AW-1:0] LBS_IRQ_MASK = 8'h18;
  localparam logic [LBS_AW-1:0] LBS_RX_STATUS = 8'h1C;

  // ***********************************************************
  // main_control fields
  // ***********************************************************
  localparam int LBS_MC_TX_MANUAL_ENABLE = 0;
  localparam int LBS_MC_TX_MANUAL_LEVEL = 1;
  localparam int LBS_MC_TRANSMITTER_ENABLE = 2;
  localparam int LBS_MC_SEND_BREAK = 3;
  localparam int LBS_MC_LIN_MODE = 4;
  localparam int LBS_MC_W = 5;
  localparam logic [LBS_MC_W-1:0] LBS_MC_RESET = 5'h00;

  // ***********************************************************
  // bus_timer_control fields
  // ***********************************************************
  localparam int LBS_TC_RUN = 0;
  localparam int LBS_TC_CLEAR_ON_FALL = 1;
  localparam int LBS_TC_COUNT_WHILE_LOW = 2;
  localparam int LBS_TC_COMPARE_SELECT = 3;
  localparam int LBS_TC_CAPTURE_A_ENABLE = 4;
  localparam int LBS_TC_CAPTURE_B_ENABLE = 5;
  localparam int LBS_TC_W = 6;
  localparam logic [LBS_TC_W-1:0] LBS_TC_RESET = 6'h00;

  // ***********************************************************
  // event bits, shared by status and mask
  // ***********************************************************
  localparam int LBS_EV_OVERFLOW = 0;
  localparam int LBS_EV_MATCH = 1;
  localparam int LBS_EV_CAPTURE_A = 2;
  localparam int LBS_EV_CAPTURE_B = 3;
  localparam int LBS_EV_RX_FALL = 4;
  localparam int LBS_EV_RX_RISE = 5;
  localparam int LBS_EV_RX_CHAR = 6;
  localparam logic [LBS_EVW-1:0] LBS_EV_RESET = 7'h00;

  // ***********************************************************
  // rx_status fields
  // ***********************************************************
  localparam int LBS_RS_BREAK = 0;
  localparam int LBS_RS_FRAME = 1;

  // ***********************************************************
  // reset values and responses
  // ***********************************************************
  localparam logic [LBS_TW-1:0] LBS_TIMER_RESET = 16'h0000;
  localparam logic [LBS_TW-1:0] LBS_TIMER_MAX = 16'hFFFF;
  localparam logic [LBS_TW-1:0] LBS_TIMER_ONE = 16'h0001;
  localparam logic [1:0] LBS_RESP_OKAY = 2'h0;
  localparam logic [1:0] LBS_RESP_SLVERR = 2'h2;

  typedef logic [LBS_TW-1:0] lbs_count_t;

endpackage

// ### lbs_cap_if.sv
// bundle between the timer core and one edge capture register
// assumes both ends share one clock
`timescale 1ns/1ps
interface lbs_cap_if;
  import lbs_pkg::*;
  logic cap_en;
  lbs_count_t cap_val;
  logic wr_en;
  lbs_count_t wr_val;
  lbs_count_t q;
  modport core (output cap_en, output cap_val, output wr_en, output wr_val, input q);
  modport store (input cap_en, input cap_val, input wr_en, input wr_val, output q);
endinterface

// ### lbs_cap_reg.sv
// one 16-bit edge capture register with software write access
// assumes capture and write requests are single-cycle pulses
`timescale 1ns/1ps
module lbs_cap_reg (
  input wire logic clk,
  input wire logic rst,
  lbs_cap_if.store port
);
  import lbs_pkg::*;

  lbs_count_t value;
  lbs_count_t next_value;

  // holds until the next qualifying edge or a software write
  always_comb begin
    next_value = value;
    if (port.cap_en) begin
      next_value = port.cap_val;
    end else if (port.wr_en) begin
      next_value = port.wr_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value <= LBS_TIMER_RESET;
    end else begin
      value <= next_value;
    end
  end

  assign port.q = value;
endmodule

// ### lbs_timer.sv
// serial bus timing extension: edge timer, captures, compare, tx pin override
// assumes RXD and framer inputs are synchronous to CLK; AXI4-Lite slave
//
// Functional notes
// - 16-bit timer counts each clock while enabled; software reads and writes it.
// - timer overflow raises a maskable overflow event.
// - capture mode latches timer into register A on each RX falling edge.
// - compare select turns register A into compare value raising match event.
// - register B latches timer on each RX rising edge, with event.
// - manual enable with transmitter off makes TX follow manual level bit.
// - count-while-low lets timer advance only while RX is low.
// - clear-on-fall zeroes the timer on each RX falling edge, then counts.
// - timer counts only while run bit is set.
// - separate enables arm capture A on falls and capture B on rises.
// - each RX falling edge raises a maskable falling-edge event.
// - each RX rising edge raises a maskable rising-edge event.
// - received-character event is raised at the commander stop bit midpoint.
// - in LIN mode no framing or break error for the all-zero pattern.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module lbs_timer (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RXD,
  input wire logic TX_SERIAL,
  input wire logic RX_STOP_MID,
  input wire logic RX_BREAK_SEEN,
  input wire logic RX_FRAME_ERR,
  output logic TXD,
  output logic TX_ENABLE,
  output logic SEND_BREAK,
  output logic IRQ,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [lbs_pkg::LBS_AW-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [lbs_pkg::LBS_DW-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [lbs_pkg::LBS_AW-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output logic RVALID,
  input wire logic RREADY,
  output logic [lbs_pkg::LBS_DW-1:0] RDATA,
  output logic [1:0] RRESP
);
  import lbs_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  logic [LBS_MC_W-1:0] main_control, next_main_control;
  logic [LBS_TC_W-1:0] bus_timer_control, next_bus_timer_control;
  lbs_count_t bus_timer_count, next_bus_timer_count;
  logic [LBS_EVW-1:0] event_status, next_event_status;
  logic [LBS_EVW-1:0] irq_mask, next_irq_mask;
  logic [1:0] rx_status, next_rx_status;
  logic rx_prev, next_rx_prev;
  logic next_txd, next_irq;
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [LBS_AW-1:0] aw_addr, next_aw_addr;
  logic [LBS_DW-1:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid, next_arready;
  logic [1:0] next_bresp, next_rresp;
  logic [LBS_DW-1:0] next_rdata;

  // working signals
  logic rx_fall, rx_rise, advance, wr_go, rd_go;
  logic [LBS_DW-1:0] wval, rval;
  logic wr_ok, rd_ok;
  logic [LBS_EVW-1:0] ev_set, ev_clr;

  lbs_cap_if cap_a ();
  lbs_cap_if cap_b ();

  lbs_cap_reg u_cap_a (
    .clk(CLK),
    .rst(RST),
    .port(cap_a)
  );

  lbs_cap_reg u_cap_b (
    .clk(CLK),
    .rst(RST),
    .port(cap_b)
  );

  // ***********************************************************
  // next-state logic
  // ***********************************************************
  always_comb begin
    next_main_control = main_control;
    next_bus_timer_control = bus_timer_control;
    next_bus_timer_count = bus_timer_count;
    next_irq_mask = irq_mask;
    next_rx_status = rx_status;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = BVALID;
    next_bresp = BRESP;
    next_rvalid = RVALID;
    next_rresp = RRESP;
    next_rdata = RDATA;
    ev_set = LBS_EV_RESET;
    ev_clr = LBS_EV_RESET;
    wr_ok = 1'b1;
    rd_ok = 1'b1;
    rval = '0;
    next_rx_prev = RXD;

    // edges of the receive line, in the first cycle at the new level
    rx_fall = rx_prev & ~RXD;
    rx_rise = ~rx_prev & RXD;

    // counter advance gating
    advance = bus_timer_control[LBS_TC_RUN]
      & (~bus_timer_control[LBS_TC_COUNT_WHILE_LOW] | ~RXD);

    // timer
    if (rx_fall && bus_timer_control[LBS_TC_CLEAR_ON_FALL]) begin
      next_bus_timer_count = LBS_TIMER_RESET;
    end else if (advance) begin
      next_bus_timer_count = bus_timer_count + LBS_TIMER_ONE;
      if (bus_timer_count == LBS_TIMER_MAX) begin
        ev_set[LBS_EV_OVERFLOW] = 1'b1;
      end
      if (bus_timer_control[LBS_TC_COMPARE_SELECT]
          && next_bus_timer_count == cap_a.q) begin
        ev_set[LBS_EV_MATCH] = 1'b1;
      end
    end

    // captures
    cap_a.cap_en = rx_fall & bus_timer_control[LBS_TC_CAPTURE_A_ENABLE]
      & ~bus_timer_control[LBS_TC_COMPARE_SELECT];
    cap_b.cap_en = rx_rise & bus_timer_control[LBS_TC_CAPTURE_B_ENABLE];
    cap_a.cap_val = bus_timer_count;
    cap_b.cap_val = bus_timer_count;
    ev_set[LBS_EV_CAPTURE_A] = cap_a.cap_en;
    ev_set[LBS_EV_CAPTURE_B] = cap_b.cap_en;
    ev_set[LBS_EV_RX_FALL] = rx_fall;
    ev_set[LBS_EV_RX_RISE] = rx_rise;
    ev_set[LBS_EV_RX_CHAR] = RX_STOP_MID;

    // write channel capture
    if (AWVALID && AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (BVALID && BREADY) begin
      next_bvalid = 1'b0;
    end

    // register write once address and data are both held
    wr_go = aw_held & w_held & ~BVALID;
    wval = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}} & w_data;
    cap_a.wr_en = 1'b0;
    cap_b.wr_en = 1'b0;
    cap_a.wr_val = wval[LBS_TW-1:0];
    cap_b.wr_val = wval[LBS_TW-1:0];
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (aw_addr == LBS_MAIN_CONTROL) begin
        next_main_control = wval[LBS_MC_W-1:0];
      end else if (aw_addr == LBS_BUS_TIMER_CONTROL) begin
        next_bus_timer_control = wval[LBS_TC_W-1:0];
      end else if (aw_addr == LBS_BUS_TIMER_VALUE) begin
        next_bus_timer_count = wval[LBS_TW-1:0];
      end else if (aw_addr == LBS_EDGE_CAPTURE_A) begin
        cap_a.wr_en = 1'b1;
      end else if (aw_addr == LBS_EDGE_CAPTURE_B) begin
        cap_b.wr_en = 1'b1;
      end else if (aw_addr == LBS_EVENT_STATUS) begin
        ev_clr = wval[LBS_EVW-1:0];
      end else if (aw_addr == LBS_IRQ_MASK) begin
        next_irq_mask = wval[LBS_EVW-1:0];
      end else if (aw_addr == LBS_RX_STATUS) begin
        next_rx_status = rx_status & ~wval[1:0];
      end else begin
        wr_ok = 1'b0;
      end
      next_bresp = wr_ok ? LBS_RESP_OKAY : LBS_RESP_SLVERR;
    end

    // receiver errors, break and framing both masked for every pattern in LIN mode
    // applied after the clear so a same-cycle error survives it
    if (!main_control[LBS_MC_LIN_MODE]) begin
      next_rx_status[LBS_RS_BREAK] = next_rx_status[LBS_RS_BREAK] | RX_BREAK_SEEN;
      next_rx_status[LBS_RS_FRAME] = next_rx_status[LBS_RS_FRAME] | RX_FRAME_ERR;
    end

    // sticky events, a new event beats a same-cycle clear
    next_event_status = (event_status & ~ev_clr) | ev_set;

    // read channel
    rd_go = ARVALID & ARREADY;
    if (RVALID && RREADY) begin
      next_rvalid = 1'b0;
    end
    if (ARADDR == LBS_MAIN_CONTROL) begin
      rval[LBS_MC_W-1:0] = main_control;
    end else if (ARADDR == LBS_BUS_TIMER_CONTROL) begin
      rval[LBS_TC_W-1:0] = bus_timer_control;
    end else if (ARADDR == LBS_BUS_TIMER_VALUE) begin
      rval[LBS_TW-1:0] = bus_timer_count;
    end else if (ARADDR == LBS_EDGE_CAPTURE_A) begin
      rval[LBS_TW-1:0] = cap_a.q;
    end else if (ARADDR == LBS_EDGE_CAPTURE_B) begin
      rval[LBS_TW-1:0] = cap_b.q;
    end else if (ARADDR == LBS_EVENT_STATUS) begin
      rval[LBS_EVW-1:0] = event_status;
    end else if (ARADDR == LBS_IRQ_MASK) begin
      rval[LBS_EVW-1:0] = irq_mask;
    end else if (ARADDR == LBS_RX_STATUS) begin
      rval[1:0] = rx_status;
    end else begin
      rd_ok = 1'b0;
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rdata = rval;
      next_rresp = rd_ok ? LBS_RESP_OKAY : LBS_RESP_SLVERR;
    end
    next_arready = ~next_rvalid & ~rd_go;

    // pins and interrupt
    if (main_control[LBS_MC_TX_MANUAL_ENABLE] && !main_control[LBS_MC_TRANSMITTER_ENABLE]) begin
      next_txd = main_control[LBS_MC_TX_MANUAL_LEVEL];
    end else begin
      next_txd = TX_SERIAL;
    end
    next_irq = |(next_event_status & next_irq_mask);
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      main_control <= LBS_MC_RESET;
      bus_timer_control <= LBS_TC_RESET;
      bus_timer_count <= LBS_TIMER_RESET;
      event_status <= LBS_EV_RESET;
      irq_mask <= LBS_EV_RESET;
      rx_status <= 2'h0;
      rx_prev <= 1'b1;
      TXD <= 1'b1;
      TX_ENABLE <= 1'b0;
      SEND_BREAK <= 1'b0;
      IRQ <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= LBS_RESP_OKAY;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= LBS_RESP_OKAY;
    end else begin
      main_control <= next_main_control;
      bus_timer_control <= next_bus_timer_control;
      bus_timer_count <= next_bus_timer_count;
      event_status <= next_event_status;
      irq_mask <= next_irq_mask;
      rx_status <= next_rx_status;
      rx_prev <= next_rx_prev;
      TXD <= next_txd;
      TX_ENABLE <= next_main_control[LBS_MC_TRANSMITTER_ENABLE];
      SEND_BREAK <= next_main_control[LBS_MC_SEND_BREAK];
      IRQ <= next_irq;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      AWREADY <= ~next_aw_held;
      WREADY <= ~next_w_held;
      BVALID <= next_bvalid;
      BRESP <= next_bresp;
      ARREADY <= next_arready;
      RVALID <= next_rvalid;
      RDATA <= next_rdata;
      RRESP <= next_rresp;
    end
  end
endmodule

// ### lbs_timer_assertions.sv
// concurrent checks on the timer block ports: bus handshakes and tx pin
// assumes a bind onto lbs_timer, one clock, reset active high
`timescale 1ns/1ps
module lbs_timer_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic TX_SERIAL,
  input wire logic TXD,
  input wire logic TX_ENABLE,
  input wire logic IRQ,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [lbs_pkg::LBS_DW-1:0] RDATA,
  input wire logic [1:0] RRESP
);
  import lbs_pkg::*;
  // ******
  // checks
  // ******
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  property p_wr_answer; AWVALID && AWREADY && WVALID && WREADY && !BVALID |=> ##1 BVALID; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write response");
  property p_aw_busy; AWVALID && AWREADY |=> !AWREADY; endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("address taken twice");
  property p_rd_answer; ARVALID && ARREADY |=> RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read data");
  property p_ar_block; ARVALID && ARREADY |=> !ARREADY ##1 (ARREADY == !RVALID); endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken too soon");
  property p_rd_done; RVALID && RREADY |=> !RVALID; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read data repeated");
  property p_b_code; BVALID |-> BRESP == LBS_RESP_OKAY || BRESP == LBS_RESP_SLVERR; endproperty
  a_b_code: assert property (p_b_code) else $error("bad write response code");
  property p_err_zero; RVALID && RRESP == LBS_RESP_SLVERR |-> RDATA == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_upper_zero; RVALID |-> RDATA[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_tx_follow; TX_ENABLE && $past(TX_ENABLE) |-> TXD == $past(TX_SERIAL); endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("tx pin not serial");
  c_write: cover property (BVALID && BREADY);
  c_slverr: cover property (RVALID && RRESP == LBS_RESP_SLVERR);
  c_irq: cover property ($rose(IRQ));
endmodule

// ### lbs_lin_node.sv
// commander node model on the bus line: break, delimiter, sync byte
// assumes callers enter its tasks just after a rising clock edge
`timescale 1ns/1ps
module lbs_lin_node (
  input wire logic clk,
  output logic rxd
);
  // *****
  // line
  // *****
  // idle line is recessive high
  initial rxd = 1'h1;
  task automatic hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic break_field(input int bt);
    hold(1'h0, 13 * bt);
    hold(1'h1, bt);
  endtask
  // start bit, byte lsb first, stop bit
  task automatic sync(input int bt);
    logic [9:0] f;
    f = {1'h1, 8'h55, 1'h0};
    for (int i = 0; i < 10; i++) begin
      hold(f[i], bt);
    end
    // gap before the identifier for baud update and fifo flush
    hold(1'h1, 2 * bt);
  endtask
endmodule

// ### testbench.sv
// self-checking bench: register map, timer, captures, compare, tx pin
// assumes lbs_timer with the line model on RXD and the checker bound
`timescale 1ns/1ps
module testbench;
  import lbs_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} lbs_row_t;
  logic CLK = 1'h0, RST = 1'h1, TX_SERIAL = 1'h1, RX_STOP_MID = 1'h0;
  logic RX_BREAK_SEEN = 1'h0, RX_FRAME_ERR = 1'h0, AWVALID = 1'h0, WVALID = 1'h0;
  logic BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, dat;
  logic [3:0] WSTRB = 4'hF;
  logic [2:0] AWPROT = 3'h0, ARPROT = 3'h0;
  logic RXD, TXD, TX_ENABLE, SEND_BREAK, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, rsp;
  int n_errors = 0, n_tests = 0;
  lbs_row_t rows [6] = '{'{8'h04, 32'h3A, 32'h3A, LBS_RESP_OKAY},
    '{8'h08, 32'h1234, 32'h1234, LBS_RESP_OKAY}, '{8'h0C, 32'hABCD, 32'hABCD, LBS_RESP_OKAY},
    '{8'h10, 32'h5A5A, 32'h5A5A, LBS_RESP_OKAY}, '{8'h18, 32'h7F, 32'h7F, LBS_RESP_OKAY},
    '{8'h20, 32'h1, 32'h0, LBS_RESP_SLVERR}};
  always #50 CLK = ~CLK;
  lbs_timer u_dut (.CLK, .RST, .RXD, .TX_SERIAL, .RX_STOP_MID, .RX_BREAK_SEEN, .RX_FRAME_ERR,
    .TXD, .TX_ENABLE, .SEND_BREAK, .IRQ, .AWVALID, .AWREADY, .AWADDR, .AWPROT, .WVALID, .WREADY,
    .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .ARPROT, .RVALID,
    .RREADY, .RDATA, .RRESP);
  lbs_lin_node u_lin (.clk(CLK), .rxd(RXD));
  // *****
  // tasks
  // *****
  task automatic conclude;
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input logic ok);
    if (!ok) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'h0;
    @(posedge CLK);
    {AWADDR, WDATA} <= {a, d};
    {AWVALID, WVALID, BREADY} <= 3'h7;
    for (int i = 0; i < 50 && !b; i++) begin
      @(negedge CLK);
      {aw, w, b, rsp} = {AWVALID & AWREADY, WVALID & WREADY, BVALID, BRESP};
      @(posedge CLK);
      if (aw) AWVALID <= 1'h0;
      if (w) WVALID <= 1'h0;
      if (b) BREADY <= 1'h0;
    end
    tmo(b);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic ar, v;
    v = 1'h0;
    @(posedge CLK);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h3;
    for (int i = 0; i < 50 && !v; i++) begin
      @(negedge CLK);
      {ar, v, dat, rsp} = {ARVALID & ARREADY, RVALID, RDATA, RRESP};
      @(posedge CLK);
      if (ar) ARVALID <= 1'h0;
      if (v) RREADY <= 1'h0;
    end
    tmo(v);
    chk(dat, e);
  endtask
  task automatic cfg(input logic [31:0] c1, v, m, c2);
    wr(8'h04, c1);
    wr(8'h08, v);
    wr(8'h18, m);
    wr(8'h14, 32'h7F);
    wr(8'h04, c2);
  endtask
  task automatic txc(input logic [31:0] m, input logic e);
    wr(8'h00, m);
    @(negedge CLK);
    chk(TXD, e);
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge CLK);
    {RX_BREAK_SEEN, RX_FRAME_ERR, RX_STOP_MID} <= p;
    @(posedge CLK);
    {RX_BREAK_SEEN, RX_FRAME_ERR, RX_STOP_MID} <= 3'h0;
  endtask
  // ********
  // stimulus
  // ********
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'h0;
    foreach (rows[k]) begin
      rc(rows[k].a, 32'h0);
      chk(rsp, rows[k].r);
      wr(rows[k].a, rows[k].d);
      chk(rsp, rows[k].r);
      rc(rows[k].a, rows[k].e);
    end
    // compare value of 9.5 bit times at 8 cycles a bit
    wr(8'h0C, 32'h4C);
    cfg(32'h08, 32'h0, 32'h02, 32'h0F);
    u_lin.break_field(8);
    rc(8'h08, 32'h67);
    rc(8'h14, 32'h32);
    @(negedge CLK);
    chk(IRQ, 32'h1);
    wr(8'h14, 32'h7F);
    repeat (2) @(negedge CLK);
    chk(IRQ, 32'h0);
    cfg(32'h00, 32'h0, 32'h10, 32'h33);
    u_lin.sync(8);
    rc(8'h0C, 32'h0F);
    rc(8'h10, 32'h07);
    rc(8'h14, 32'h3C);
    @(negedge CLK);
    chk(IRQ, 32'h1);
    cfg(32'h05, 32'hFFFE, 32'h01, 32'h05);
    u_lin.hold(1'h0, 5);
    u_lin.hold(1'h1, 2);
    rc(8'h08, 32'h03);
    rc(8'h14, 32'h31);
    rc(8'h0C, 32'h0F);
    rc(8'h10, 32'h07);
    txc(32'h01, 1'h0);
    txc(32'h03, 1'h1);
    @(posedge CLK);
    TX_SERIAL <= 1'h0;
    txc(32'h0F, 1'h0);
    chk(TX_ENABLE, 32'h1);
    chk(SEND_BREAK, 32'h1);
    wr(8'h00, 32'h10);
    wr(8'h14, 32'h7F);
    pulse(3'h7);
    rc(8'h1C, 32'h0);
    rc(8'h14, 32'h40);
    wr(8'h00, 32'h0);
    pulse(3'h6);
    rc(8'h1C, 32'h3);
    wr(8'h1C, 32'h3);
    rc(8'h1C, 32'h0);
    // reset in mid-run: pin and registers back to their reset state
    @(posedge CLK);
    RST <= 1'h1;
    repeat (2) @(posedge CLK);
    chk(TXD, 32'h1);
    chk(IRQ, 32'h0);
    RST <= 1'h0;
    rc(8'h08, 32'h0);
    rc(8'h04, 32'h0);
    rc(8'h14, 32'h0);
    rc(8'h18, 32'h0);
    conclude();
  end
endmodule
bind lbs_timer lbs_timer_assertions u_chk (.CLK, .RST, .TX_SERIAL, .TXD, .TX_ENABLE, .IRQ,
  .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID,
  .RREADY, .RDATA, .RRESP);
